/* File: bridge_slot_clock_config_regs.v */
// Slot identification and secondary clock control registers of a
// PCI Express to PCI bridge, reached over AXI4-Lite.
// Assumes power state, idle and electrical idle come from aclk logic.
`timescale 1ns/1ps
`default_nettype none
module bridge_slot_clock_config_regs
#(
  parameter SLOTS = 4
)
(
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire forward_mode,
  input wire eeprom_load_valid,
  input wire eeprom_si_enable,
  input wire sec_bus_idle,
  input wire primary_req_pending,
  input wire rx_elec_idle,
  input wire l0s_request,
  input wire sec_clk_in,
  output wire slot0_clock_out,
  output wire slot1_clock_out,
  output wire slot2_clock_out,
  output wire slot3_clock_out,
  output reg sec_clk_stopped,
  output reg l0s_enter
);
  `include "slot_clock_consts.vh"

  // ========================================================
  // Register state
  reg [1:0] pm_state_q;
  reg si_enable_q;
  reg [4:0] slot_num_q;
  reg first_in_chassis_q;
  reg [7:0] chassis_q;
  reg [7:0] slot_en_q;
  reg run_en_q;
  reg stop_mode_q;
  reg l0s_qual_q;
  reg [1:0] scr_q;

  // ========================================================
  // Write channel: address and data taken in either order
  reg aw_held_q;
  reg [7:0] aw_addr_q;
  reg w_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire do_write;
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign do_write = aw_held_q && w_held_q;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(aw_addr_q) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = ({a[7:2], 2'b00} == `OFF_PM_CSR) ||
                ({a[7:2], 2'b00} == `OFF_SLOT_IDENT) ||
                ({a[7:2], 2'b00} == `OFF_SEC_CLK_CTRL) ||
                ({a[7:2], 2'b00} == `OFF_SI_ENABLE);
    end
  endfunction

  // ========================================================
  // Register updates
  wire [7:0] wa;
  assign wa = {aw_addr_q[7:2], 2'b00};

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pm_state_q <= 2'b00;
      si_enable_q <= 1'b0;
      slot_num_q <= `SLOT_NUM_RST;
      first_in_chassis_q <= 1'b0;
      chassis_q <= `CHASSIS_RST;
      slot_en_q <= `SCC_SLOT_EN_RST;
      run_en_q <= 1'b0;
      stop_mode_q <= 1'b0;
      l0s_qual_q <= `SCC_L0S_QUAL_RST;
      scr_q <= `SCC_SCR_RST;
    end
    else
    begin
      // Slot ident is switched on only by the serial memory load
      if (eeprom_load_valid)
        si_enable_q <= eeprom_si_enable;
      if (do_write && wa == `OFF_PM_CSR && w_strb_q[0])
      begin
        // D1 and D2 are not implemented, such writes are dropped
        if (w_data_q[1:0] == 2'b00 || w_data_q[1:0] == `PM_STATE_D3HOT)
          pm_state_q <= w_data_q[1:0];
      end
      if (do_write && wa == `OFF_SLOT_IDENT && si_enable_q)
      begin
        if (w_strb_q[2])
        begin
          slot_num_q <= w_data_q[20:16];
          first_in_chassis_q <= w_data_q[21];
        end
        if (w_strb_q[3])
          chassis_q <= w_data_q[31:24];
      end
      if (do_write && wa == `OFF_SEC_CLK_CTRL)
      begin
        if (w_strb_q[0])
          slot_en_q <= w_data_q[7:0];
        if (w_strb_q[1])
        begin
          run_en_q <= w_data_q[`SCC_RUN_EN];
          stop_mode_q <= w_data_q[`SCC_STOP_MODE];
        end
        if (w_strb_q[2])
        begin
          l0s_qual_q <= w_data_q[`SCC_L0S_QUAL];
          scr_q <= w_data_q[`SCC_SCR_HI:`SCC_SCR_LO];
        end
      end
    end
  end

  // ========================================================
  // Bridge mode strap
  // The strap is a pin with no timing to aclk; two flops keep a late
  // change from reaching the four slot gates in different cycles.
  reg fwd_meta_q;
  reg fwd_sync_q;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fwd_meta_q <= 1'b0;
      fwd_sync_q <= 1'b0;
    end
    else
    begin
      fwd_meta_q <= forward_mode;
      fwd_sync_q <= fwd_meta_q;
    end
  end

  // ========================================================
  // Secondary clock stop and L0s qualifier
  wire in_d3hot;
  wire stop_cond;
  assign in_d3hot = (pm_state_q == `PM_STATE_D3HOT);
  assign stop_cond = run_en_q &&
    (stop_mode_q ? (sec_bus_idle && !primary_req_pending)
                 : in_d3hot);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sec_clk_stopped <= 1'b0;
      l0s_enter <= 1'b0;
    end
    else
    begin
      sec_clk_stopped <= stop_cond;
      // Qualifier gates the request on receiver electrical idle
      l0s_enter <= l0s_request && (!l0s_qual_q || rx_elec_idle);
    end
  end

  // ========================================================
  // Slot clock gates
  // The gate ANDs a registered bit into the clock; the source must be
  // the aclk source or the slot outputs may carry runt pulses.
  wire [SLOTS-1:0] slot_clk;
  genvar g;
  generate
    for (g = 0; g < SLOTS; g = g + 1)
    begin : gate
      slot_clock_gate u_gate
      (
        .aclk(aclk),
        .aresetn(aresetn),
        .sec_clk_in(sec_clk_in),
        .enable_field(slot_en_q[2*g+1:2*g]),
        .forward_mode(fwd_sync_q),
        .bus_stopped(sec_clk_stopped),
        .clock_out(slot_clk[g])
      );
    end
  endgenerate
  assign slot0_clock_out = slot_clk[0];
  assign slot1_clock_out = slot_clk[1];
  assign slot2_clock_out = slot_clk[2];
  assign slot3_clock_out = slot_clk[3];

  // ========================================================
  // Read channel
  reg [31:0] rd_word;
  wire [7:0] ra;
  assign ra = {s_axi_araddr[7:2], 2'b00};
  assign s_axi_arready = !s_axi_rvalid;

  always @*
  begin
    rd_word = 32'h00000000;
    case (ra)
      // Data byte and bridge-support bits stay zero
      `OFF_PM_CSR: rd_word = {16'h0000, 14'h0000, pm_state_q};
      `OFF_SLOT_IDENT:
        if (si_enable_q)
          rd_word = {chassis_q, 2'b00, first_in_chassis_q, slot_num_q,
                     `SLOT_IDENT_NEXT_PTR, `SLOT_IDENT_CAP_ID};
      `OFF_SEC_CLK_CTRL:
        rd_word = {13'h0000, scr_q, l0s_qual_q, stop_mode_q, run_en_q,
                   sec_clk_stopped, 5'h00, slot_en_q};
      `OFF_SI_ENABLE: rd_word = {31'h00000000, si_enable_q};
      default: rd_word = 32'h00000000;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= addr_ok(s_axi_araddr) ? 2'b00 : 2'b10;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

/* File: bridge_slot_clock_config_regs_sva.sv */
// Checker for the slot and secondary clock register group.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module slot_clock_regs_chk
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic l0s_request,
  input wire logic rx_elec_idle,
  input wire logic l0s_enter,
  input wire logic sec_clk_stopped,
  input wire logic slot0_clock_out
);
  // ==========================================================
  // Bus handshakes
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  a_wr_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer not released");
  a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  // ==========================================================
  // Power and clock side
  a_l0s_cause: assert property (l0s_enter |-> $past(l0s_request))
    else $error("l0s entered without request");
  a_l0s_idle: assert property (l0s_request && rx_elec_idle |=> l0s_enter)
    else $error("l0s refused in electrical idle");
  // Three cycles allow for the register and the gate stage
  a_slot_stop: assert property (sec_clk_stopped[*3] |-> !slot0_clock_out)
    else $error("slot clock runs while bus stopped");
endmodule
bind bridge_slot_clock_config_regs slot_clock_regs_chk slot_clock_regs_chk_inst (.*);
`default_nettype wire

/* File: bridge_slot_clock_config_regs_test.sv */
// Self-checking bench for the slot and secondary clock registers.
// Assumes the checker file is compiled alongside for the bind.
`timescale 1ns/1ps
`default_nettype none
module bridge_slot_clock_config_regs_test;
  logic aclk=0, aresetn=0, s_axi_awvalid=0, s_axi_wvalid=0, s_axi_bready=0;
  logic s_axi_arvalid=0, s_axi_rready=0, forward_mode=1, eeprom_load_valid=0;
  logic eeprom_si_enable=1, sec_bus_idle=0, primary_req_pending=0;
  logic rx_elec_idle=0, l0s_request=0, sec_clk_in=1;
  logic [7:0] s_axi_awaddr=0, s_axi_araddr=0;
  logic [31:0] s_axi_wdata=0, rd_q;
  logic [3:0] s_axi_wstrb=4'hf;
  logic [1:0] resp_q;
  wire [31:0] s_axi_rdata;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire slot0_clock_out, slot1_clock_out, slot2_clock_out, slot3_clock_out;
  wire sec_clk_stopped, l0s_enter;
  int mismatches=0, n_tests=0;
  bridge_slot_clock_config_regs bridge_slot_clock_config_regs_inst (.*);
  always #10 aclk = ~aclk;
  // ==========================================================
  // Bus and compare tasks
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 0;
    resp_q = s_axi_bresp;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    @(posedge aclk iff s_axi_arready);
    s_axi_arvalid <= 0;
    @(posedge aclk iff s_axi_rvalid);
    s_axi_rready <= 0;
    rd_q = s_axi_rdata;
    resp_q = s_axi_rresp;
  endtask
  task wait3;
    repeat (3) @(posedge aclk);
  endtask
  // ==========================================================
  // Scenarios
  task t_regs;
    rd(8'h94);
    chk(rd_q & 32'hffc0_0003, 0);
    rd(8'ha4);
    chk(rd_q, 32'h0001_0000);
    rd(8'ha0);
    chk(rd_q, 0);
    @(posedge aclk);
    eeprom_load_valid <= 1;
    @(posedge aclk);
    eeprom_load_valid <= 0;
    rd(8'ha0);
    chk(rd_q, 32'h0000_b004);
    wr(8'ha0, 32'hffff_ffff);
    chk(resp_q, 0);
    rd(8'ha0);
    chk(rd_q, 32'hff3f_b004);
    wr(8'ha4, 32'hffff_ffff);
    rd(8'ha4);
    chk(rd_q, 32'h0007_c0ff);
    wr(8'h98, 1);
    chk(resp_q, 2);
    rd(8'h98);
    chk(rd_q, 0);
    chk(resp_q, 2);
    wr(8'h94, 32'hff00_0001);
    rd(8'h94);
    chk(rd_q, 0);
  endtask
  task t_slots;
    for (int i = 0; i < 4; i++)
      for (int v = 0; v < 4; v++)
      begin
        wr(8'ha4, 32'h0001_0000 | (v << (2 * i)));
        wait3;
        chk({slot3_clock_out, slot2_clock_out, slot1_clock_out,
          slot0_clock_out}, (v == 3) ? 4'hf & ~(4'h1 << i) : 4'hf);
      end
    sec_clk_in <= 0;
    wait3;
    chk({slot3_clock_out, slot2_clock_out, slot1_clock_out,
      slot0_clock_out}, 0);
    sec_clk_in <= 1;
    @(posedge aclk);
    forward_mode <= 0;
    wr(8'ha4, 32'h0001_00ff);
    wait3;
    chk({slot3_clock_out, slot2_clock_out, slot1_clock_out,
      slot0_clock_out}, 4'hf);
    forward_mode <= 1;
  endtask
  task t_l0s;
    @(posedge aclk);
    l0s_request <= 1;
    wr(8'ha4, 32'h0001_0000);
    wait3;
    chk(l0s_enter, 0);
    rx_elec_idle <= 1;
    wait3;
    chk(l0s_enter, 1);
    rx_elec_idle <= 0;
    wr(8'ha4, 0);
    wait3;
    chk(l0s_enter, 1);
  endtask
  task t_stop;
    @(posedge aclk);
    sec_bus_idle <= 1;
    wr(8'ha4, 32'h0001_c000);
    wait3;
    chk(sec_clk_stopped, 1);
    rd(8'ha4);
    chk(rd_q, 32'h0001_e000);
    wait3;
    chk(slot0_clock_out, 0);
    primary_req_pending <= 1;
    wait3;
    chk(sec_clk_stopped, 0);
    primary_req_pending <= 0;
    wr(8'ha4, 32'h0001_4000);
    wait3;
    chk(sec_clk_stopped, 0);
    wr(8'h94, 3);
    wait3;
    chk(sec_clk_stopped, 1);
    wr(8'ha4, 32'h0000_8000);
    wait3;
    chk(sec_clk_stopped, 0);
    rd(8'ha4);
    chk(rd_q, 32'h0000_8000);
  endtask
  task end_of_test;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    t_regs;
    t_slots;
    t_l0s;
    t_stop;
    end_of_test;
  end
  initial
  begin
    #200us;
    mismatches++;
    end_of_test;
  end
endmodule
`default_nettype wire

/* File: slot_clock_consts.vh */
// Constants for the bridge slot and secondary clock register group.
// Assumes inclusion by bare name from design files of this block.
`ifndef SLOT_CLOCK_CONSTS_VH
`define SLOT_CLOCK_CONSTS_VH

// ==========================================================
// Register byte addresses
`define OFF_PM_CSR 8'h94
`define OFF_SLOT_IDENT 8'ha0
`define OFF_SEC_CLK_CTRL 8'ha4
`define OFF_SI_ENABLE 8'hc0

// ==========================================================
// Fixed field values
`define SLOT_IDENT_CAP_ID 8'h04
`define SLOT_IDENT_NEXT_PTR 8'hb0
`define PM_STATE_D3HOT 2'b11
`define SLOT_CLK_OFF 2'b11

// ==========================================================
// Secondary clock control field positions
`define SCC_STOP_STAT 13
`define SCC_RUN_EN 14
`define SCC_STOP_MODE 15
`define SCC_L0S_QUAL 16
`define SCC_SCR_LO 17
`define SCC_SCR_HI 18

// ==========================================================
// Reset values
`define SCC_SLOT_EN_RST 8'h00
`define SCC_L0S_QUAL_RST 1'b1
`define SCC_SCR_RST 2'b00
`define SLOT_NUM_RST 5'h00
`define CHASSIS_RST 8'h00

`endif

/* File: slot_clock_gate.v */
// Gate for one slot clock output: stops and holds low when disabled.
// Assumes the source clock is the bridge secondary clock.
`timescale 1ns/1ps
`default_nettype none
module slot_clock_gate
(
  input wire aclk,
  input wire aresetn,
  input wire sec_clk_in,
  input wire [1:0] enable_field,
  input wire forward_mode,
  input wire bus_stopped,
  output wire clock_out
);
  `include "slot_clock_consts.vh"
  reg run_q;
  // Enable registered so the gate changes on a bridge clock edge only
  always @(posedge aclk)
  begin
    if (!aresetn)
      run_q <= 1'b1;
    else
      run_q <= !((forward_mode && enable_field == `SLOT_CLK_OFF) ||
                 bus_stopped);
  end
  assign clock_out = sec_clk_in & run_q;
endmodule
`default_nettype wire
